// ### qtbf_top.sv
// Quad burst framer core: serial bus, processor port and four line sections.
//
// Overview of operation
// - All link timing comes from master clock.
// - Delayed frame pulse copy drives the chain.
// - Line bits sent as AMI at 512 kbps.
// - Space idles both outputs; mark is differential.
// - Burst: start bit, 20 data, two spaces.
// - Data: two bearers, signalling and maintenance.
// - Bearers on serial bus; nibbles via processor.
// - Serial bus: 2048 kbps, 32 slots, frame pulse.
// - Input sampled mid bit on falling edge.
// - Output changes at bit start, falling edge.
// - Section n uses slots 2n and 2n+1.
// - Output floats outside owned slots.
// - Buffer enable high while output driven.
// - Owned slots are fixed at 0 to 7; there is no slot offset for sharing the bus.
// - Section n registers answer at address n.
// - Address captured on address strobe fall.
// - Only the two low address bits decoded.
// - Transfers only while chip select low.
// - Nibble: signalling hi, lo, maintenance hi, lo.
// - Address and data share processor lines.
// - Device is the burst-initiating master end.
`timescale 1ns/1ps
`default_nettype none
module qtbf_top #(
  parameter int WINDOW_CYCLES = qtbf_pkg::WINDOW_CYCLES
) (
  // System clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Serial bus timing.
  input wire logic master_clock_in,
  input wire logic frame_sync_in_n,
  output var logic frame_sync_out_n,
  // Serial bus data.
  input wire logic serial_stream_in,
  output var logic serial_stream_out,
  output var logic serial_stream_oe,
  output var logic stream_buffer_enable,
  // Line pins, one bit per section.
  input wire logic [qtbf_pkg::SECTIONS-1:0] line_rx_mark,
  output wire logic [qtbf_pkg::SECTIONS-1:0] line_out_pos,
  output wire logic [qtbf_pkg::SECTIONS-1:0] line_out_neg,
  // Processor port.
  input wire logic cpu_ale,
  input wire logic cpu_cs_n,
  input wire logic cpu_rd_n,
  input wire logic cpu_wr_n,
  input wire logic [qtbf_pkg::NIB_W-1:0] cpu_ad_in,
  output var logic [qtbf_pkg::NIB_W-1:0] cpu_ad_out,
  output var logic cpu_ad_oe
);
  import qtbf_pkg::*;

  localparam int WIN_W = $clog2(WINDOW_CYCLES + 1);

  // ==========================================================================
  // State of the master clock domain
  // ==========================================================================
  typedef struct packed {
    qtbf_cnt_t cnt;
    logic aligned;
    logic fs_out_n;
    logic so;
    logic soe;
    logic sbe;
    logic [SLOT_BITS-2:0] in_sr;
    logic [SECTIONS-1:0][1:0][SLOT_BITS-1:0] txb;
    logic [SECTIONS-1:0][1:0][SLOT_BITS-1:0] rxb;
    qtbf_nib_s [SECTIONS-1:0] rx_nib;
    qtbf_nib_s [SECTIONS-1:0] tx_nib;
    logic fr_tgl;
    logic tt_s1;
    logic tt_s2;
    logic tt_s3;
  } qtbf_link_s;

  // ==========================================================================
  // State of the system clock domain
  // ==========================================================================
  typedef struct packed {
    logic ale_s1;
    logic ale_s2;
    logic ale_s3;
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic rd_s1;
    logic rd_s2;
    logic wr_s1;
    logic wr_s2;
    logic wr_s3;
    logic [NIB_W-1:0] ad_s1;
    logic [NIB_W-1:0] ad_s2;
    logic [ADDR_W-1:0] addr;
    qtbf_nib_s [SECTIONS-1:0] txn;
    qtbf_nib_s [SECTIONS-1:0] rxn;
    logic fr_s1;
    logic fr_s2;
    logic fr_s3;
    logic [WIN_W-1:0] win_cnt;
    logic win_open;
    logic tx_flip;
    logic [NIB_W-1:0] ad_out;
    logic ad_oe;
  } qtbf_cpu_s;

  qtbf_link_s lk_q, lk_d;
  qtbf_cpu_s cp_q, cp_d;
  wire qtbf_burst_s [SECTIONS-1:0] tx_b;
  wire qtbf_burst_s [SECTIONS-1:0] rx_b;
  qtbf_slot_t slot;
  qtbf_sbit_t sbit;
  logic own;
  logic [ADDR_W-1:0] sec;
  logic brr;

  // ==========================================================================
  // Line sections
  // ==========================================================================
  for (genvar s = 0; s < SECTIONS; s++) begin : g_sec
    // Bearer bytes leave the serial bus toward the line.
    assign tx_b[s] = {lk_q.txb[s][0], lk_q.txb[s][1], lk_q.tx_nib[s]};
    qtbf_section u_sec (
      .mclk(master_clock_in),
      .sys_rst(sys_rst),
      .cnt(lk_q.cnt),
      .tx_burst(tx_b[s]),
      .rx_burst(rx_b[s]),
      .line_rx_mark(line_rx_mark[s]),
      .line_pos(line_out_pos[s]),
      .line_neg(line_out_neg[s])
    );
  end

  // ==========================================================================
  // Serial bus and frame timing
  // ==========================================================================
  always_comb begin
    lk_d = lk_q;
    // A frame pulse seen low restarts the frame at bit 0 of slot 0.
    lk_d.cnt = frame_sync_in_n ? qtbf_cnt_t'(lk_q.cnt + 1'b1) : '0;
    lk_d.fs_out_n = frame_sync_in_n;
    // The bus stays released until the first frame pulse fixes the slots.
    if (!frame_sync_in_n) begin
      lk_d.aligned = 1'b1;
    end
    if (lk_d.cnt == '0) begin
      // Frame boundary: hand the finished bursts to both consumers.
      lk_d.fr_tgl = ~lk_q.fr_tgl;
      for (int s = 0; s < SECTIONS; s++) begin
        lk_d.rxb[s][0] = rx_b[s].bearer_first;
        lk_d.rxb[s][1] = rx_b[s].bearer_second;
        lk_d.rx_nib[s] = rx_b[s].nib;
      end
    end
    slot = slot_of(lk_d.cnt);
    sbit = sbit_of(lk_d.cnt);
    own = lk_d.aligned && (slot < OWNED_SLOTS);
    sec = slot[ADDR_W:1];
    brr = slot[0];
    if (!lk_d.cnt[0]) begin
      // Bit cell start: drive, or float outside the owned slots.
      lk_d.soe = own;
      lk_d.sbe = own;
      lk_d.so = own & lk_d.rxb[sec][brr][~sbit];
    end else if (own) begin
      // Mid cell: sample, most significant bit first.
      lk_d.in_sr = {lk_q.in_sr[SLOT_BITS-3:0], serial_stream_in};
      if (sbit == qtbf_sbit_t'(SLOT_BITS - 1)) begin
        lk_d.txb[sec][brr] = {lk_q.in_sr, serial_stream_in};
      end
    end
    // Written nibbles are stable once the toggle is seen.
    lk_d.tt_s1 = cp_q.tx_flip;
    lk_d.tt_s2 = lk_q.tt_s1;
    lk_d.tt_s3 = lk_q.tt_s2;
    if (lk_q.tt_s2 != lk_q.tt_s3) begin
      lk_d.tx_nib = cp_q.txn;
    end
  end

  always_ff @(negedge master_clock_in or posedge sys_rst) begin
    if (sys_rst) begin
      lk_q <= '0;
      lk_q.fs_out_n <= 1'b1;
    end else begin
      lk_q <= lk_d;
    end
  end

  assign frame_sync_out_n = lk_q.fs_out_n;
  assign serial_stream_out = lk_q.so;
  assign serial_stream_oe = lk_q.soe;
  assign stream_buffer_enable = lk_q.sbe;

  // ==========================================================================
  // Processor port
  // ==========================================================================
  always_comb begin
    cp_d = cp_q;
    cp_d.ale_s1 = cpu_ale;
    cp_d.ale_s2 = cp_q.ale_s1;
    cp_d.ale_s3 = cp_q.ale_s2;
    cp_d.cs_s1 = cpu_cs_n;
    cp_d.cs_s2 = cp_q.cs_s1;
    cp_d.cs_s3 = cp_q.cs_s2;
    cp_d.rd_s1 = cpu_rd_n;
    cp_d.rd_s2 = cp_q.rd_s1;
    cp_d.wr_s1 = cpu_wr_n;
    cp_d.wr_s2 = cp_q.wr_s1;
    cp_d.wr_s3 = cp_q.wr_s2;
    cp_d.ad_s1 = cpu_ad_in;
    cp_d.ad_s2 = cp_q.ad_s1;
    cp_d.fr_s1 = lk_q.fr_tgl;
    cp_d.fr_s2 = cp_q.fr_s1;
    cp_d.fr_s3 = cp_q.fr_s2;
    if (cp_q.ale_s3 && !cp_q.ale_s2) begin
      cp_d.addr = cp_q.ad_s2[ADDR_W-1:0];
    end
    if (cp_q.fr_s2 != cp_q.fr_s3) begin
      // New frame: open the window and show the latest bursts.
      cp_d.win_cnt = '0;
      cp_d.win_open = 1'b1;
      cp_d.rxn = lk_q.rx_nib;
    end else if (cp_q.win_open) begin
      cp_d.win_cnt = WIN_W'(cp_q.win_cnt + 1'b1);
      if (cp_q.win_cnt == WIN_W'(WINDOW_CYCLES - 1)) begin
        // Window closed: pass the written nibbles to the line side.
        cp_d.win_open = 1'b0;
        cp_d.tx_flip = ~cp_q.tx_flip;
      end
    end
    // Write completes on the rising write strobe under chip select.
    if (cp_q.win_open && !cp_q.cs_s3 && cp_q.wr_s2 && !cp_q.wr_s3) begin
      cp_d.txn[cp_q.addr] = cp_q.ad_s2;
    end
    cp_d.ad_oe = !cp_q.cs_s2 && !cp_q.rd_s2;
    cp_d.ad_out = cp_q.rxn[cp_q.addr];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cp_q <= '0;
      cp_q.cs_s1 <= 1'b1;
      cp_q.cs_s2 <= 1'b1;
      cp_q.cs_s3 <= 1'b1;
      cp_q.rd_s1 <= 1'b1;
      cp_q.rd_s2 <= 1'b1;
      cp_q.wr_s1 <= 1'b1;
      cp_q.wr_s2 <= 1'b1;
      cp_q.wr_s3 <= 1'b1;
    end else begin
      cp_q <= cp_d;
    end
  end

  assign cpu_ad_out = cp_q.ad_out;
  assign cpu_ad_oe = cp_q.ad_oe;

  // ==========================================================================
  // Checks on the serial bus
  // ==========================================================================
  a_oe_owned_slots: assert property (
    @(negedge master_clock_in) disable iff (sys_rst)
    lk_q.cnt[0] |-> (serial_stream_oe
      == (lk_q.aligned && (slot_of(lk_q.cnt) < OWNED_SLOTS))))
    else $error("Bus drive does not match the owned slots.");
  a_oe_starts_slot0: assert property (
    @(negedge master_clock_in) disable iff (sys_rst)
    $rose(serial_stream_oe) |-> (lk_q.cnt == '0))
    else $error("Bus drive began away from slot 0.");
  a_buffer_follows: assert property (
    @(negedge master_clock_in) disable iff (sys_rst)
    stream_buffer_enable == serial_stream_oe)
    else $error("Buffer enable differs from bus drive.");
  a_fsync_delay: assert property (
    @(negedge master_clock_in) disable iff (sys_rst)
    !frame_sync_in_n |=> !frame_sync_out_n ##1 frame_sync_out_n)
    else $error("Frame pulse copy wrong.");
  a_frame_restart: assert property (
    @(negedge master_clock_in) disable iff (sys_rst)
    !frame_sync_in_n |=> (lk_q.cnt == '0) ##1 (lk_q.cnt == qtbf_cnt_t'(1)))
    else $error("Frame pulse did not restart the frame.");
  a_out_at_bit_start: assert property (
    @(negedge master_clock_in) disable iff (sys_rst)
    $changed(serial_stream_out) |-> !lk_q.cnt[0])
    else $error("Serial output changed mid bit.");
  c_aligned: cover property (
    @(negedge master_clock_in) disable iff (sys_rst)
    $rose(lk_q.aligned));
  c_frame_seen: cover property (
    @(negedge master_clock_in) disable iff (sys_rst)
    !frame_sync_in_n ##1 serial_stream_oe);

  // ==========================================================================
  // Checks on the processor port
  // ==========================================================================
  a_write_window: assert property (
    @(posedge clk) disable iff (sys_rst)
    $changed(cp_q.txn) |-> $past(cp_q.win_open))
    else $error("Register written outside the access window.");
  a_window_handoff: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(cp_q.win_open) |-> ($changed(cp_q.tx_flip)
      && ($past(cp_q.win_cnt) == WIN_W'(WINDOW_CYCLES - 1))))
    else $error("Window end did not hand over the nibbles.");
  a_read_drive: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!cp_q.cs_s2 && !cp_q.rd_s2) |=> cpu_ad_oe)
    else $error("Read under chip select not answered.");
  a_read_data: assert property (
    @(posedge clk) disable iff (sys_rst)
    cpu_ad_oe |-> (cpu_ad_out == $past(cp_q.rxn[cp_q.addr])))
    else $error("Read data not from the addressed section.");
  a_addr_latch: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(cp_q.ale_s2) |=> (cp_q.addr == $past(cp_q.ad_s2[ADDR_W-1:0])))
    else $error("Address not taken at strobe fall.");
  c_write_in_window: cover property (
    @(posedge clk) disable iff (sys_rst)
    $changed(cp_q.txn));
  c_read: cover property (
    @(posedge clk) disable iff (sys_rst)
    $rose(cpu_ad_oe));

endmodule // qtbf_top
`default_nettype wire

// ### qtbf_pkg.sv
// Shared constants, carriers and decode functions of the quad burst framer.
package qtbf_pkg;

  // ==========================================================================
  // Clock and frame timing
  // ==========================================================================
  localparam int MCLK_KHZ = 4096;
  localparam int FRAME_KHZ = 8;
  localparam int LINE_KBPS = 512;
  localparam int PCM_KBPS = 2048;
  localparam int FRAME_CLKS = MCLK_KHZ / FRAME_KHZ;
  localparam int LINE_BIT_CLKS = MCLK_KHZ / LINE_KBPS;
  localparam int PCM_BIT_CLKS = MCLK_KHZ / PCM_KBPS;
  localparam int CNT_W = $clog2(FRAME_CLKS);
  localparam int PCM_PH_W = $clog2(PCM_BIT_CLKS);
  localparam int LINE_PH_W = $clog2(LINE_BIT_CLKS);
  localparam int LINE_MID = LINE_BIT_CLKS / 2;

  // Processor access window after each frame pulse, in system clocks.
  localparam int WINDOW_NS = 115000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int WINDOW_CYCLES = WINDOW_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Bus and burst layout
  // ==========================================================================
  localparam int SECTIONS = 4;
  localparam int SLOT_BITS = 8;
  localparam int SLOT_BIT_W = $clog2(SLOT_BITS);
  localparam int SLOT_W = CNT_W - PCM_PH_W - SLOT_BIT_W;
  localparam int OWNED_SLOTS = 2 * SECTIONS;
  localparam int ADDR_W = $clog2(SECTIONS);
  localparam int NIB_W = 4;
  localparam int BURST_BITS = 23;
  localparam int DATA_BITS = 20;
  localparam int TAIL_BITS = 2;
  localparam int RXN_W = $clog2(DATA_BITS);

  typedef logic [CNT_W-1:0] qtbf_cnt_t;
  typedef logic [SLOT_W-1:0] qtbf_slot_t;
  typedef logic [SLOT_BIT_W-1:0] qtbf_sbit_t;
  typedef logic [CNT_W-LINE_PH_W-1:0] qtbf_lbit_t;
  typedef logic [LINE_PH_W-1:0] qtbf_lph_t;

  typedef struct packed {
    logic sig_hi;
    logic sig_lo;
    logic maint_hi;
    logic maint_lo;
  } qtbf_nib_s;

  // Packing order is the order of the data bits on the line.
  typedef struct packed {
    logic [SLOT_BITS-1:0] bearer_first;
    logic [SLOT_BITS-1:0] bearer_second;
    qtbf_nib_s nib;
  } qtbf_burst_s;

  typedef enum logic [1:0] {
    rx_idle = 2'b00,
    rx_hunt = 2'b01,
    rx_data = 2'b10
  } qtbf_rx_e;

  // ==========================================================================
  // Frame position decoders
  // ==========================================================================
  function automatic qtbf_slot_t slot_of(qtbf_cnt_t c);
    return c[CNT_W-1:CNT_W-SLOT_W];
  endfunction

  function automatic qtbf_sbit_t sbit_of(qtbf_cnt_t c);
    return c[PCM_PH_W+SLOT_BIT_W-1:PCM_PH_W];
  endfunction

  function automatic qtbf_lbit_t lbit_of(qtbf_cnt_t c);
    return c[CNT_W-1:LINE_PH_W];
  endfunction

  function automatic qtbf_lph_t lph_of(qtbf_cnt_t c);
    return c[LINE_PH_W-1:0];
  endfunction

endpackage

// ### qtbf_section.sv
// One transceiver section: burst transmitter, AMI coder and burst receiver.
`timescale 1ns/1ps
`default_nettype none
module qtbf_section (
  // Master clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Frame position.
  input wire qtbf_pkg::qtbf_cnt_t cnt,
  // Burst payloads.
  input wire qtbf_pkg::qtbf_burst_s tx_burst,
  output var qtbf_pkg::qtbf_burst_s rx_burst,
  // Line pins.
  input wire logic line_rx_mark,
  output var logic line_pos,
  output var logic line_neg
);
  import qtbf_pkg::*;

  typedef struct packed {
    logic mk_s1;
    logic mk_s2;
    logic [DATA_BITS+TAIL_BITS-1:0] tx_sr;
    logic pol;
    logic pos;
    logic neg;
    qtbf_rx_e rx_st;
    logic [RXN_W-1:0] rx_n;
    logic [DATA_BITS-1:0] rx_sr;
    qtbf_burst_s rx_out;
  } qtbf_sec_s;

  qtbf_sec_s q, d;
  logic mark;

  always_comb begin
    d = q;
    mark = 1'b0;
    d.mk_s1 = line_rx_mark;
    d.mk_s2 = q.mk_s1;
    if (lph_of(cnt) == '0) begin
      if (cnt == '0) begin
        mark = 1'b1;
        d.tx_sr = {tx_burst, {TAIL_BITS{1'b0}}};
      end else if (lbit_of(cnt) < BURST_BITS) begin
        mark = q.tx_sr[DATA_BITS+TAIL_BITS-1];
        d.tx_sr = {q.tx_sr[DATA_BITS+TAIL_BITS-2:0], 1'b0};
      end
      // Marks alternate polarity; a space leaves both outputs idle.
      d.pos = mark & q.pol;
      d.neg = mark & ~q.pol;
      if (mark) begin
        d.pol = ~q.pol;
      end
    end
    if (cnt == '0) begin
      d.rx_st = rx_idle;
    end else if (lph_of(cnt) == qtbf_lph_t'(LINE_MID)) begin
      case (q.rx_st)
        rx_idle: begin
          if (lbit_of(cnt) == qtbf_lbit_t'(BURST_BITS)) begin
            d.rx_st = rx_hunt;
          end
        end
        rx_hunt: begin
          if (q.mk_s2) begin
            d.rx_st = rx_data;
            d.rx_n = '0;
          end
        end
        rx_data: begin
          d.rx_sr = {q.rx_sr[DATA_BITS-2:0], q.mk_s2};
          d.rx_n = q.rx_n + 1'b1;
          if (q.rx_n == RXN_W'(DATA_BITS - 1)) begin
            d.rx_out = {q.rx_sr[DATA_BITS-2:0], q.mk_s2};
            d.rx_st = rx_idle;
          end
        end
        default: d.rx_st = rx_idle;
      endcase
    end
  end

  always_ff @(negedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rx_burst = q.rx_out;
  assign line_pos = q.pos;
  assign line_neg = q.neg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_line_not_both: assert property (@(negedge mclk) disable iff (sys_rst)
    !(line_pos && line_neg))
    else $error("Both line outputs driven at once.");
  a_burst_starts: assert property (@(negedge mclk) disable iff (sys_rst)
    (cnt == '0) |=> (line_pos || line_neg))
    else $error("Burst did not open with a mark.");
  a_tail_space: assert property (@(negedge mclk) disable iff (sys_rst)
    (lbit_of(cnt) > qtbf_lbit_t'(BURST_BITS)) |-> !(line_pos || line_neg))
    else $error("Line not idle after the burst.");
  a_line_rate: assert property (@(negedge mclk) disable iff (sys_rst)
    $changed({line_pos, line_neg}) |-> (lph_of(cnt) == qtbf_lph_t'(1)))
    else $error("Line output moved off a line bit boundary.");
  c_burst_rx: cover property (@(negedge mclk) disable iff (sys_rst)
    (q.rx_st == rx_data) ##1 (q.rx_st == rx_idle));

endmodule // qtbf_section
`default_nettype wire

// ### qtbf_far_end.sv
// Far-side model: switch timing and bus data, plus an echoing remote line end.
`timescale 1ns/1ps
`default_nettype none
module qtbf_far_end (
  // Bus timing and data.
  output var logic master_clock_in,
  output var logic frame_sync_in_n,
  output var logic serial_stream_in,
  output var logic [8:0] mcnt,
  output var logic [7:0] frame_no,
  // Line.
  input wire logic [3:0] line_out_pos,
  input wire logic [3:0] line_out_neg,
  output var logic [3:0] line_rx_mark
);
  logic [799:0] echo_q;
  logic [8:0] n;
  logic [7:0] f;
  logic [7:0] b;
  initial begin
    master_clock_in = 1'b0;
    frame_sync_in_n = 1'b1;
    serial_stream_in = 1'b0;
    mcnt = 9'h190;
    frame_no = 8'h00;
    echo_q = '0;
    line_rx_mark = 4'h0;
  end
  // ==========================================================================
  // Master clock, frame pulse and slot data
  // ==========================================================================
  always #15 master_clock_in = ~master_clock_in;
  always @(negedge master_clock_in) begin
    n = mcnt + 9'h001;
    f = frame_no + {7'h00, n == 9'h000};
    b = {f[2:0], n[8:4]};
    mcnt <= n;
    frame_no <= f;
    frame_sync_in_n <= (n != 9'h1ff);
    if (!n[0]) begin
      serial_stream_in <= b[~n[3:1]];
    end
    // The remote end answers only after the master's burst has ended.
    echo_q <= {echo_q[795:0], line_out_pos | line_out_neg};
    line_rx_mark <= echo_q[799:796];
  end
endmodule // qtbf_far_end
`default_nettype wire

// ### testbench.sv
// Self-checking bench of the quad burst framer with bus, line and host traffic.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module testbench;
  logic clk, sys_rst, master_clock_in, frame_sync_in_n, frame_sync_out_n;
  logic serial_stream_in, serial_stream_out, serial_stream_oe;
  logic stream_buffer_enable, cpu_ale, cpu_cs_n, cpu_rd_n, cpu_wr_n, cpu_ad_oe;
  logic [3:0] line_rx_mark, line_out_pos, line_out_neg, cpu_ad_in, cpu_ad_out;
  logic [8:0] mcnt, c;
  logic [7:0] frame_no, eb;
  logic [5:0] k;
  logic [19:0] bur;
  logic [3:0][3:0] nib_next, nib_cur;
  logic [3:0] last_pos = 4'h0;
  logic nib_set = 1'b0, nib_ok = 1'b0, em;
  int mismatches = 0, num_checks = 0, cycles = 0;

  qtbf_top #(.WINDOW_CYCLES(400)) uut (.clk(clk), .sys_rst(sys_rst),
    .master_clock_in(master_clock_in), .frame_sync_in_n(frame_sync_in_n),
    .frame_sync_out_n(frame_sync_out_n), .serial_stream_in(serial_stream_in),
    .serial_stream_out(serial_stream_out), .serial_stream_oe(serial_stream_oe),
    .stream_buffer_enable(stream_buffer_enable), .line_rx_mark(line_rx_mark),
    .line_out_pos(line_out_pos), .line_out_neg(line_out_neg),
    .cpu_ale(cpu_ale), .cpu_cs_n(cpu_cs_n), .cpu_rd_n(cpu_rd_n),
    .cpu_wr_n(cpu_wr_n), .cpu_ad_in(cpu_ad_in), .cpu_ad_out(cpu_ad_out),
    .cpu_ad_oe(cpu_ad_oe));
  qtbf_far_end far (.master_clock_in(master_clock_in),
    .frame_sync_in_n(frame_sync_in_n), .serial_stream_in(serial_stream_in),
    .mcnt(mcnt), .frame_no(frame_no), .line_out_pos(line_out_pos),
    .line_out_neg(line_out_neg), .line_rx_mark(line_rx_mark));

  // ==========================================================================
  // Clock, timeout and verdict
  // ==========================================================================
  always #4 clk = ~clk;
  task automatic report_and_stop;
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 16000) begin
      mismatches++;
      report_and_stop;
    end
  end

  // ==========================================================================
  // Bus and line monitor, sampled between the master's falling edges
  // ==========================================================================
  always @(posedge master_clock_in) begin
    c = mcnt;
    k = c[8:3];
    eb = {3'(frame_no - 8'h02), c[8:4]};
    if (c == 9'h000) begin
      nib_cur <= nib_next;
      nib_ok <= nib_set;
    end
    if (!sys_rst && frame_no >= 8'h01) begin
      `CHK(frame_sync_out_n, c != 9'h000)
      `CHK(serial_stream_oe, c[8:7] == 2'b00)
      `CHK(stream_buffer_enable, c[8:7] == 2'b00)
    end
    if (!sys_rst && frame_no >= 8'h03)
      `CHK(serial_stream_out, (c[8:7] == 2'b00) & eb[~c[3:1]])
    for (int s = 0; s < 4; s++) begin
      if (!sys_rst)
        `CHK(line_out_pos[s] & line_out_neg[s], 1'b0)
      if (!sys_rst && c[2:0] == 3'h4) begin
        bur = {3'(frame_no - 8'h01), 5'(2 * s), 3'(frame_no - 8'h01),
          5'(2 * s + 1), nib_cur[s]};
        em = (k == 6'h00);
        if (k >= 6'h01 && k <= 6'h14)
          em = bur[20 - k];
        if (frame_no >= 8'h02 && (nib_ok || k < 6'h11))
          `CHK(line_out_pos[s] | line_out_neg[s], em)
        if (line_out_pos[s] | line_out_neg[s]) begin
          if (frame_no >= 8'h02)
            `CHK(line_out_pos[s], ~last_pos[s])
          last_pos[s] = line_out_pos[s];
        end
      end
    end
  end

  // ==========================================================================
  // Processor port cycles
  // ==========================================================================
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic addr(input logic [3:0] a);
    cpu_ale <= 1'b1;
    cpu_ad_in <= a;
    cyc(4);
    cpu_ale <= 1'b0;
    cyc(4);
  endtask
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    addr(a);
    cpu_ad_in <= d;
    cpu_cs_n <= 1'b0;
    cpu_wr_n <= 1'b0;
    cyc(4);
    cpu_wr_n <= 1'b1;
    cyc(4);
    cpu_cs_n <= 1'b1;
    cyc(4);
  endtask
  task automatic rd(input logic [3:0] a, input logic sel, input logic [3:0] e);
    addr(a);
    cpu_cs_n <= ~sel;
    cpu_rd_n <= 1'b0;
    cyc(5);
    `CHK(cpu_ad_oe, sel)
    if (sel)
      `CHK(cpu_ad_out, e)
    cpu_rd_n <= 1'b1;
    cpu_cs_n <= 1'b1;
    cyc(5);
    `CHK(cpu_ad_oe, 1'b0)
  endtask
  task automatic wait_frame(input logic [7:0] f);
    while (frame_no != f)
      @(posedge clk);
    cyc(8);
  endtask
  function automatic logic [3:0] v1(input int s);
    return 4'(s * 5 + 3);
  endfunction

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    cpu_ale = 1'b0;
    cpu_cs_n = 1'b1;
    cpu_rd_n = 1'b1;
    cpu_wr_n = 1'b1;
    cpu_ad_in = 4'h0;
    cyc(4);
    sys_rst <= 1'b0;
    wait_frame(8'h01);
    for (int s = 0; s < 4; s++) begin
      wr(4'(s) | {s[0], s[0], 2'b00}, v1(s));
      nib_next[s] = v1(s);
    end
    nib_set = 1'b1;
    cyc(600);
    wr(4'h0, 4'h5);
    wait_frame(8'h02);
    rd(4'h1, 1'b0, 4'h0);
    wait_frame(8'h03);
    for (int s = 0; s < 4; s++)
      rd(4'(s) | {~s[0], 3'b000}, 1'b1, v1(s));
    for (int s = 0; s < 4; s++) begin
      wr(4'(s), ~v1(s));
      nib_next[s] = ~v1(s);
    end
    wait_frame(8'h05);
    for (int s = 0; s < 4; s++)
      rd(4'(s), 1'b1, ~v1(s));
    wait_frame(8'h06);
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
